// ---- adc_ctrl_consts.vh ----
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH
// ===========================================================
// register byte addresses
`define OFS_CONTROL      12'h000
`define OFS_RESULT_HIGH  12'h004
`define OFS_RESULT_LOW   12'h008
`define OFS_JUSTIFY      12'h00C
`define OFS_IRQ_STATUS   12'h010
`define OFS_IRQ_ENABLE   12'h014
`define OFS_IRQ_CLEAR    12'h018
// ===========================================================
// control register fields
`define CTL_SEL_HI       6
`define CTL_SEL_LO       2
`define CTL_CONVERT      1
`define CTL_POWER        0
`define CTL_RESET        8'h00
`define JUS_BIT          0
// ===========================================================
// input select codes
`define SEL_LAST_EXT     5'h03
`define SEL_TEMP         5'h1D
`define SEL_DAC          5'h1E
`define SEL_FVR          5'h1F
// ===========================================================
// analog mux one-hot outputs
`define MUX_NONE         7'h00
`define MUX_TEMP         7'h10
`define MUX_DAC          7'h20
`define MUX_FVR          7'h40
`define MUX_EXT_W        4
// ===========================================================
// interrupt bits
`define IRQ_DONE         0
`define IRQ_W            1
// ===========================================================
// result layout
`define RES_W            10
`define BYTE_ZERO        8'h00
`define WORD_ZERO        32'h00000000
`define ADDR_W           12
`define ADDR_LSB         2
`endif

// ---- result_store.v ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_consts.vh"
// ===========================================================
// result byte pair storage; no reset so content survives all
// resets except power-on, which leaves it unknown
module result_store (
  input  wire       pclk,      // system clock
  input  wire       wr_high,   // write high byte
  input  wire       wr_low,    // write low byte
  input  wire [7:0] high_data, // high byte write data
  input  wire [7:0] low_data,  // low byte write data
  output reg  [7:0] high,      // stored high byte
  output reg  [7:0] low        // stored low byte
);
  always @(posedge pclk) begin
    if (wr_high) begin
      high <= high_data;
    end
    if (wr_low) begin
      low <= low_data;
    end
  end
endmodule // result_store
`default_nettype wire

// ---- adc_control_and_result.v ----
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_consts.vh"
// ===========================================================
// register map: one byte-wide register in the low byte of each
// word, upper bits read zero
//   0x00 control: select code in 6:2, convert flag in 1, enable
//        in 0; bit 7 reads zero
//   0x04 result high byte, read and write
//   0x08 result low byte, read and write
//   0x0C justify select in bit 0, set for right justified
//   0x10 interrupt status, read only, bit 0 marks a finished
//        conversion
//   0x14 interrupt enable, same layout as status
//   0x18 interrupt clear, write one to clear, reads zero
// any other word answers with an error and reads zero; the result
// bytes have no reset, so they keep their content across a reset
// and are unknown until first written or converted
// Behaviour
// - select codes 0 to 3 route analog inputs 0 to 3 to the converter.
// - codes 4 through 28 are reserved and connect no channel.
// - codes 29, 30, 31 connect temperature, DAC output and reference.
// - the convert flag reads one while a conversion is running.
// - the enable bit powers the converter; clear means no current.
// - left justified, high byte holds result bits 9 to 2.
// - left justified, low byte holds bits 1 and 0 in positions 7 and 6.
// - right justified, high byte holds bits 9 and 8 in positions 1, 0.
// - right justified, low byte holds result bits 7 to 0.
// - result bytes are writable and untouched by any reset.
module adc_control_and_result (
  input  wire        pclk,          // system clock
  input  wire        presetn,       // async reset, low active
  input  wire        psel,          // apb select
  input  wire        penable,       // apb enable
  input  wire        pwrite,        // apb direction
  input  wire [11:0] paddr,         // apb byte address
  input  wire [31:0] pwdata,        // apb write data
  output reg  [31:0] prdata,        // apb read data
  output reg         pready,        // apb ready
  output reg         pslverr,       // apb error
  output reg         core_power,    // converter power enable
  output reg         core_start,    // one-cycle start pulse
  input  wire        core_done,     // conversion done pulse
  input  wire [9:0]  core_result,   // finished result
  output reg  [6:0]  mux_select,    // one-hot analog input select
  output reg         irq            // interrupt level
);
  // ===========================================================
  // state
  reg  [4:0] input_select_field;
  wire       converting;
  reg        converter_power_on;
  reg        result_justify_select;
  reg  [`IRQ_W-1:0] irq_status;
  reg  [`IRQ_W-1:0] irq_enable;
  reg        done_s1;
  reg        done_s2;
  reg        done_d;
  reg  [9:0] res_s1;
  reg  [9:0] res_s2;
  wire       done_pulse;
  wire       acc;
  wire       wr;
  wire       rd;
  wire       hit_ctl;
  wire       hit_hi;
  wire       hit_lo;
  wire       hit_jus;
  wire       hit_sta;
  wire       hit_ena;
  wire       hit_clr;
  wire       mapped;
  wire       finish;
  reg  [7:0] next_high;
  reg  [7:0] next_low;
  reg        wr_high;
  reg        wr_low;
  reg  [7:0] high_data;
  reg  [7:0] low_data;
  wire       ctl_wr;
  wire       go_req;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg        start_now;
  // conversion sequencer states, one-hot
  localparam [2:0] ST_OFF  = 3'b001; // enable bit clear
  localparam [2:0] ST_IDLE = 3'b010; // powered, no conversion
  localparam [2:0] ST_BUSY = 3'b100; // conversion in flight
  wire [7:0] high;
  wire [7:0] low;
  reg  [6:0] next_mux;
  reg  [31:0] next_rdata;
  // ===========================================================
  // done crosses from the analog core clock domain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_d  <= 1'b0;
    end else begin
      done_s1 <= core_done;
      done_s2 <= done_s1;
      done_d  <= done_s2;
    end
  end
  // the core holds its result steady from before done rises, so a
  // plain two-flop copy has settled by the time the edge is seen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_s1 <= 10'h000;
      res_s2 <= 10'h000;
    end else begin
      res_s1 <= core_result;
      res_s2 <= res_s1;
    end
  end
  assign done_pulse = done_s2 & ~done_d;
  assign converting = (state == ST_BUSY);
  // a done seen while powered off or idle is stale and ignored
  assign finish = done_pulse & converting & converter_power_on;
  // ===========================================================
  // apb decode
  assign acc     = psel & penable & pready;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign hit_ctl = (paddr == `OFS_CONTROL);
  assign hit_hi  = (paddr == `OFS_RESULT_HIGH);
  assign hit_lo  = (paddr == `OFS_RESULT_LOW);
  assign hit_jus = (paddr == `OFS_JUSTIFY);
  assign hit_sta = (paddr == `OFS_IRQ_STATUS);
  assign hit_ena = (paddr == `OFS_IRQ_ENABLE);
  assign hit_clr = (paddr == `OFS_IRQ_CLEAR);
  assign mapped  = hit_ctl | hit_hi | hit_lo | hit_jus | hit_sta |
                   hit_ena | hit_clr;
  assign ctl_wr  = wr & hit_ctl;
  assign go_req  = ctl_wr & pwdata[`CTL_CONVERT] & pwdata[`CTL_POWER];
  // ===========================================================
  // control register fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select_field <= 5'h00;
      converter_power_on <= 1'b0;
    end else if (ctl_wr) begin
      input_select_field <= pwdata[`CTL_SEL_HI:`CTL_SEL_LO];
      converter_power_on <= pwdata[`CTL_POWER];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_justify_select <= 1'b0;
    end else if (wr && hit_jus) begin
      result_justify_select <= pwdata[`JUS_BIT];
    end
  end
  // the core sees the enable one cycle after the register bit, so one
  // cycle after the start pulse of a write that sets both
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_power <= 1'b0;
    end else begin
      core_power <= converter_power_on;
    end
  end
  // ===========================================================
  // conversion sequencer; a start written with the enable clear is
  // ignored, so the flag never reads one while unpowered
  always @* begin
    next_state = state;
    start_now  = 1'b0;
    case (state)
      ST_OFF: begin
        if (go_req) begin
          next_state = ST_BUSY;
          start_now  = 1'b1;
        end else if (ctl_wr && pwdata[`CTL_POWER]) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (go_req) begin
          next_state = ST_BUSY;
          start_now  = 1'b1;
        end else if (ctl_wr && !pwdata[`CTL_POWER]) begin
          next_state = ST_OFF;
        end
      end
      ST_BUSY: begin
        if (go_req) begin
          // a start landing on the finishing cycle begins a new one
          start_now = finish;
        end else if (ctl_wr) begin
          // flag written low aborts; enable written low powers off
          next_state = pwdata[`CTL_POWER] ? ST_IDLE : ST_OFF;
        end else if (finish) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_OFF;
      core_start <= 1'b0;
    end else begin
      state      <= next_state;
      core_start <= start_now;
    end
  end
  // ===========================================================
  // analog mux select
  always @* begin
    next_mux = `MUX_NONE;
    if (input_select_field <= `SEL_LAST_EXT) begin
      next_mux = {3'b000, 4'b0001 << input_select_field[1:0]};
    end else begin
      case (input_select_field)
        `SEL_TEMP: next_mux = `MUX_TEMP;
        `SEL_DAC:  next_mux = `MUX_DAC;
        `SEL_FVR:  next_mux = `MUX_FVR;
        default:   next_mux = `MUX_NONE;
      endcase
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_select <= `MUX_NONE;
    end else begin
      mux_select <= next_mux;
    end
  end
  // ===========================================================
  // result justification and store; hardware result wins
  always @* begin
    if (result_justify_select) begin
      next_high = {6'h00, res_s2[9:8]};
      next_low  = res_s2[7:0];
    end else begin
      next_high = res_s2[9:2];
      next_low  = {res_s2[1:0], 6'h00};
    end
  end
  // a finishing conversion owns both byte write ports in its cycle;
  // a software byte write landing in that cycle is dropped
  always @* begin
    wr_high   = finish | (wr & hit_hi);
    wr_low    = finish | (wr & hit_lo);
    high_data = finish ? next_high : pwdata[7:0];
    low_data  = finish ? next_low  : pwdata[7:0];
  end
  result_store u_store (
    .pclk      (pclk),
    .wr_high   (wr_high),
    .wr_low    (wr_low),
    .high_data (high_data),
    .low_data  (low_data),
    .high      (high),
    .low       (low)
  );
  // ===========================================================
  // interrupt enable and status; a done landing on a clear wins, so
  // no finished conversion goes unreported
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= 1'b0;
    end else if (wr && hit_ena) begin
      irq_enable <= pwdata[`IRQ_DONE];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 1'b0;
    end else if (finish) begin
      irq_status <= 1'b1;
    end else if (wr && hit_clr && pwdata[`IRQ_DONE]) begin
      irq_status <= 1'b0;
    end
  end
  // the line lags the status by one cycle so it leaves a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end
  // ===========================================================
  // apb read path; one wait state lets read data come from a flop
  always @* begin
    next_rdata = `WORD_ZERO;
    case (paddr)
      `OFS_CONTROL: begin
        next_rdata = {24'h000000, 1'b0, input_select_field,
                      converting, converter_power_on};
      end
      `OFS_RESULT_HIGH: begin
        next_rdata = {24'h000000, high};
      end
      `OFS_RESULT_LOW: begin
        next_rdata = {24'h000000, low};
      end
      `OFS_JUSTIFY: begin
        next_rdata = {31'h00000000, result_justify_select};
      end
      `OFS_IRQ_STATUS: begin
        next_rdata = {31'h00000000, irq_status};
      end
      `OFS_IRQ_ENABLE: begin
        next_rdata = {31'h00000000, irq_enable};
      end
      default: begin
        next_rdata = `WORD_ZERO;
      end
    endcase
  end
  // every access takes one wait state: pready rises on the first
  // access-phase edge, so a master must never assume zero wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `WORD_ZERO;
    end else if (psel && penable && !pready) begin
      prdata <= pwrite ? `WORD_ZERO : next_rdata;
    end
  end
endmodule // adc_control_and_result
`default_nettype wire

// ---- adc_control_and_result_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// port checks for the converter control block
module adc_control_and_result_asserts (
  input wire logic        pclk,        // clock
  input wire logic        presetn,     // reset
  input wire logic        psel,        // select
  input wire logic        penable,     // enable
  input wire logic        pwrite,      // direction
  input wire logic [11:0] paddr,       // address
  input wire logic [31:0] pwdata,      // write data
  input wire logic [31:0] prdata,      // read data
  input wire logic        pready,      // ready
  input wire logic        pslverr,     // error
  input wire logic        core_power,  // core power
  input wire logic        core_start,  // start pulse
  input wire logic        core_done,   // done
  input wire logic [9:0]  core_result, // result
  input wire logic [6:0]  mux_select,  // input select
  input wire logic        irq          // interrupt
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // control write completing at this edge; mux checks wait two
  // edges so either register stage inside the block is allowed
  wire       ctl_wr = psel && penable && pready && pwrite && paddr == 12'h000;
  wire [4:0] code   = pwdata[6:2];
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_late: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  a_mux_onehot: assert property ($onehot0(mux_select))
    else $error("select not one-hot");
  a_mux_reserved: assert property (
    ctl_wr && pwdata[0] && code > 5'h03 && code < 5'h1D
    |-> ##2 mux_select == 7'h00) else $error("reserved code routed");
  a_mux_sensor: assert property (
    ctl_wr && pwdata[0] && code == 5'h1D |-> ##2 mux_select == 7'h10)
    else $error("sensor not routed");
  a_start_pulse: assert property (core_start |=> !core_start)
    else $error("start too long");
  a_start_taken: assert property (
    ctl_wr && pwdata[1:0] == 2'b11 |-> ##[1:2] core_start)
    else $error("start missing");
  a_start_refused: assert property (
    ctl_wr && !pwdata[0] |=> !core_start [*3])
    else $error("start while off");
  a_power_follows: assert property (
    ctl_wr |-> ##2 core_power == $past(pwdata[0], 2))
    else $error("power not following");
endmodule // adc_control_and_result_asserts
`default_nettype wire

// ---- test_adc_control_and_result.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_consts.vh"
// ===========================================================
// bench
module test_adc_control_and_result;
  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0;
  logic        core_done   = 1'b0;
  logic [9:0]  core_result = 10'h000;
  wire  [31:0] prdata;
  wire  [6:0]  mux_select;
  wire         pready, pslverr, core_power, core_start, irq;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          n_start      = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (core_start === 1'b1) n_start++;
  adc_control_and_result u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_power(core_power),
    .core_start(core_start), .core_done(core_done),
    .core_result(core_result), .mux_select(mux_select), .irq(irq));
  // ===========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ===========================================================
  // scenarios
  task automatic t_mux;
    logic [6:0] e;
    apb(0, `OFS_CONTROL, 32'h0);
    chk(rd, {24'h0, `CTL_RESET});
    for (int c = 0; c < 32; c++) begin
      e = (c < 4) ? 7'h01 << c : (c == 29) ? `MUX_TEMP :
          (c == 30) ? `MUX_DAC : (c == 31) ? `MUX_FVR : `MUX_NONE;
      apb(1, `OFS_CONTROL, 32'(c * 4 + 1));
      tick(2);
      chk({25'h0, mux_select}, {25'h0, e});
      chk({31'h0, core_power}, 32'h1);
    end
    apb(1, `OFS_CONTROL, 32'h0);
    tick(2);
    chk({31'h0, core_power}, 32'h0);
  endtask
  task automatic t_conv(input logic j, input logic [9:0] r);
    int n;
    int s;
    n = 0;
    s = n_start;
    core_result <= r;
    apb(1, `OFS_JUSTIFY, {31'h0, j});
    apb(1, `OFS_IRQ_ENABLE, 32'h1);
    apb(1, `OFS_CONTROL, 32'h3);
    apb(0, `OFS_CONTROL, 32'h0);
    chk(rd & 32'h2, 32'h2);
    chk(32'(n_start), 32'(s + 1));
    core_done <= 1'b1;
    tick(2);
    core_done <= 1'b0;
    do begin
      apb(0, `OFS_CONTROL, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 10);
    chk(rd & 32'h2, 32'h0);
    apb(0, `OFS_RESULT_HIGH, 32'h0);
    if (!j) chk(rd & 32'hFF, {24'h0, r[9:2]});
    else chk(rd & 32'h3, {30'h0, r[9:8]});
    apb(0, `OFS_RESULT_LOW, 32'h0);
    if (!j) chk(rd & 32'hC0, {24'h0, r[1:0], 6'h0});
    else chk(rd & 32'hFF, {24'h0, r[7:0]});
    apb(0, `OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1, `OFS_IRQ_ENABLE, 32'h0);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    apb(1, `OFS_IRQ_CLEAR, 32'h1);
    apb(1, `OFS_IRQ_ENABLE, 32'h1);
    apb(0, `OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_refuse;
    int s;
    s = n_start;
    apb(1, `OFS_CONTROL, 32'h2);
    tick(4);
    chk(32'(n_start), 32'(s));
    apb(0, `OFS_CONTROL, 32'h0);
    chk(rd & 32'h2, 32'h0);
    // a running conversion is aborted by writing the flag low
    apb(1, `OFS_CONTROL, 32'h3);
    apb(1, `OFS_CONTROL, 32'h1);
    apb(0, `OFS_CONTROL, 32'h0);
    chk(rd & 32'h3, 32'h1);
    chk(32'(n_start), 32'(s + 1));
    apb(0, 12'h01C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
  endtask
  // result bytes must survive a reset that is not power-on
  task automatic t_keep;
    apb(1, `OFS_RESULT_HIGH, 32'hA5);
    apb(1, `OFS_RESULT_LOW, 32'h5A);
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    apb(0, `OFS_RESULT_HIGH, 32'h0);
    chk(rd & 32'hFF, 32'hA5);
    apb(0, `OFS_RESULT_LOW, 32'h0);
    chk(rd & 32'hFF, 32'h5A);
  endtask
  initial begin
    tick(3);
    presetn <= 1'b1;
    t_mux();
    t_conv(1'b0, 10'h2D6);
    t_conv(1'b1, 10'h1A5);
    t_refuse();
    t_keep();
    final_report();
  end
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
endmodule // test_adc_control_and_result
bind adc_control_and_result adc_control_and_result_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_power(core_power),
  .core_start(core_start), .core_done(core_done),
  .core_result(core_result), .mux_select(mux_select), .irq(irq));
`default_nettype wire
